// ===== rtl/uart_event_regs.svh
// Purpose: register offsets, field positions, response codes and counts of
//          the serial event and interrupt controller.
// Assumes: byte addresses on an AXI4-Lite bus, one aligned word each.
`ifndef UART_EVENT_REGS_SVH
`define UART_EVENT_REGS_SVH

`define REG_CTRL 8'h00
`define REG_FIFO_THR 8'h04
`define REG_RX_DATA 8'h08
`define REG_TX_DATA 8'h0c
`define REG_FIFO_STAT 8'h10
`define REG_TMR0_CFG 8'h14
`define REG_TMR1_CFG 8'h18
`define REG_TMR_CMD 8'h1c
`define REG_TMR_STAT 8'h20
`define REG_USER_CC 8'h24
`define REG_INT_STATUS 8'h28
`define REG_INT_CLEAR 8'h2c
`define REG_INT_ENABLE 8'h30
`define REG_BLK_ENABLE 8'h34
`define REG_TOP_BLOCK 8'h38
`define REG_BLK_SUMMARY 8'h3c

`define FIFO_DEPTH 4
`define TMR_MODE_BIT 16
`define THR_TX_LSB 4
`define CC_ASCII_LIM 8'h20
`define CC_ASCII_DEL 8'h7f
`define CC_EBCDIC_LIM 8'h40
`define CC_EBCDIC_EO 8'hff

// source bit positions; block id doubles as priority, 0 highest
`define SRC_RXM_LO 5'd0
`define SRC_RXM_HI 5'd5
`define SRC_RXF_LO 5'd6
`define SRC_RXF_HI 5'd7
`define SRC_TXF_LO 5'd8
`define SRC_TXF_HI 5'd8
`define SRC_TXM_LO 5'd9
`define SRC_TXM_HI 5'd11
`define SRC_TMR_LO 5'd12
`define SRC_TMR_HI 5'd13
`define SRC_MDM_LO 5'd14
`define SRC_MDM_HI 5'd19
`define NONE_PENDING 3'h7

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== rtl/uart_event_pkg.sv
// Purpose: types of the serial event and interrupt controller.
// Assumes: two timers of fixed width, twenty sources, six blocks.
// Notes: the controller state apart from the FIFO character storage is one packed struct.
package uart_event_pkg;

    localparam int NSRC = 20;
    localparam int NBLK = 6;
    localparam int TMR_W = 16;

    typedef enum logic [1:0] {
        CC_ASCII,
        CC_EBCDIC,
        CC_USER,
        CC_OFF
    } cc_mode_t;

    typedef struct packed {
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bus_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic [1:0] wp;
        logic [1:0] rp;
    } fifo_t;

    typedef struct packed {
        bus_t bus;
        logic ack_manual;
        cc_mode_t cc_mode;
        logic [2:0] rx_thr;
        logic [2:0] tx_thr;
        fifo_t rx;
        fifo_t tx;
        logic [1:0][TMR_W-1:0] tmr_cnt;
        logic [1:0][TMR_W-1:0] tmr_rel;
        logic [1:0] tmr_baud;
        logic [1:0] tmr_run;
        logic [1:0] tick;
        logic [15:0] user_cc;
        logic [NSRC-1:0] pend;
        logic [NSRC-1:0] src_en;
        logic [NBLK-1:0] blk_en;
        logic [5:0] mdm_s1;
        logic [5:0] mdm_s2;
        logic [5:0] mdm_s3;
    } state_t;

endpackage : uart_event_pkg

// ===== rtl/char_fifo_mem.sv
// Purpose: character storage of one FIFO, registered read port.
// Assumes: read address is the head pointer the FIFO will hold next cycle.
// Notes: a write to the address being read is passed straight through.
`timescale 1ns/100ps
module char_fifo_mem #(
    parameter int DEPTH = 4,
    parameter int WIDTH = 8,
    parameter int AW = 2
) (
    // clock
    input wire logic clk_i,
    // write port
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    // read port
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
        // bypass keeps the head valid right after a push into an empty FIFO
        if (we_i && (waddr_i == raddr_i)) begin
            rdata_o <= wdata_i;
        end else begin
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule : char_fifo_mem

// ===== rtl/uart_event_offload.sv
// Purpose: FIFOs, timers, control character detection and the prioritised
//          interrupt controller of an asynchronous serial controller.
// Assumes: character and event inputs come from logic on CLK_SYS_I; modem
//          lines are pins and are synchronised here.
// Notes: registers reached over AXI4-Lite; see uart_event_regs.svh.
`timescale 1ns/100ps
`include "uart_event_regs.svh"
module uart_event_offload (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // axi4-lite write
    input wire logic [7:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    // axi4-lite read
    input wire logic [7:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    // receive machine
    input wire logic [7:0] RX_CHAR_I,
    input wire logic RX_CHAR_VALID_I,
    input wire logic [4:0] RX_EVT_I,
    // transmit machine
    output logic [7:0] TX_CHAR_O,
    output logic TX_CHAR_VALID_O,
    input wire logic TX_CHAR_READY_I,
    input wire logic [2:0] TX_EVT_I,
    // modem lines
    input wire logic [5:0] MODEM_I,
    // baud ticks and interrupt
    output logic [1:0] BAUD_TICK_O,
    output logic IRQ_O
);
    localparam int NSRC = uart_event_pkg::NSRC;
    localparam int NBLK = uart_event_pkg::NBLK;
    localparam int TW = uart_event_pkg::TMR_W;

    uart_event_pkg::state_t s_q;
    uart_event_pkg::state_t s_d;

    logic [7:0] rx_head;
    logic [7:0] tx_head;
    logic rx_push;
    logic tx_push;
    logic [NSRC-1:0] live;
    logic [NBLK-1:0] blk_pend;
    logic [2:0] top_blk;
    logic [4:0] top_src;

    // merge byte lanes of a write into a register value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // source bits that belong to one block
    function automatic logic [NSRC-1:0] blk_mask(input logic [2:0] b);
        logic [4:0] lo;
        logic [4:0] hi;
        logic [NSRC-1:0] m;
        lo = `SRC_RXM_LO;
        hi = `SRC_RXM_HI;
        m = '0;
        unique case (b)
            3'h0: begin lo = `SRC_RXM_LO; hi = `SRC_RXM_HI; end
            3'h1: begin lo = `SRC_RXF_LO; hi = `SRC_RXF_HI; end
            3'h2: begin lo = `SRC_TXF_LO; hi = `SRC_TXF_HI; end
            3'h3: begin lo = `SRC_TXM_LO; hi = `SRC_TXM_HI; end
            3'h4: begin lo = `SRC_TMR_LO; hi = `SRC_TMR_HI; end
            3'h5: begin lo = `SRC_MDM_LO; hi = `SRC_MDM_HI; end
            default: return '0;
        endcase
        for (int i = 0; i < NSRC; i++) begin
            m[i] = (5'(i) >= lo) && (5'(i) <= hi);
        end
        return m;
    endfunction : blk_mask

    // lowest set bit of a source vector
    function automatic logic [4:0] lowest(input logic [NSRC-1:0] v);
        logic [4:0] r;
        r = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : lowest

    function automatic logic cc_match(input uart_event_pkg::cc_mode_t m,
                                      input logic [7:0] c,
                                      input logic [15:0] u);
        unique case (m)
            uart_event_pkg::CC_ASCII:
                return (c < `CC_ASCII_LIM) || (c == `CC_ASCII_DEL);
            uart_event_pkg::CC_EBCDIC:
                return (c < `CC_EBCDIC_LIM) || (c == `CC_EBCDIC_EO);
            uart_event_pkg::CC_USER:
                return (c == u[7:0]) || (c == u[15:8]);
            uart_event_pkg::CC_OFF:
                return 1'b0;
        endcase
    endfunction : cc_match

    // interrupt resolution from registered state
    always_comb begin
        live = s_q.pend & s_q.src_en;
        for (int b = 0; b < NBLK; b++) begin
            blk_pend[b] = |(live & blk_mask(3'(b)));
        end
        top_blk = `NONE_PENDING;
        for (int b = NBLK - 1; b >= 0; b--) begin
            if (blk_pend[b] && s_q.blk_en[b]) begin
                top_blk = 3'(b);
            end
        end
        top_src = lowest(live & blk_mask(top_blk));
    end

    assign rx_push = RX_CHAR_VALID_I && (s_q.rx.cnt != 3'(`FIFO_DEPTH));

    always_comb begin
        logic do_wr;
        logic rd_fire;
        logic rx_pop;
        logic tx_pop;
        logic [7:0] wa;
        logic [7:0] ra;
        logic [31:0] wv;
        logic [31:0] rv;
        logic map_ok;
        logic [NSRC-1:0] set;
        logic [NSRC-1:0] clr;
        logic [1:0] load;
        do_wr = 1'b0;
        rd_fire = 1'b0;
        rx_pop = 1'b0;
        tx_pop = 1'b0;
        wa = '0;
        ra = '0;
        wv = '0;
        rv = '0;
        map_ok = 1'b1;
        set = '0;
        clr = '0;
        load = '0;
        tx_push = 1'b0;
        s_d = s_q;

        // write address and data may arrive in either order
        if (AWVALID_I && AWREADY_O) begin
            s_d.bus.aw_full = 1'b1;
            s_d.bus.aw_addr = AWADDR_I;
        end
        if (WVALID_I && WREADY_O) begin
            s_d.bus.w_full = 1'b1;
            s_d.bus.wdata = WDATA_I;
            s_d.bus.wstrb = WSTRB_I;
        end
        if (BVALID_O && BREADY_I) begin
            s_d.bus.bvalid = 1'b0;
        end
        if (s_d.bus.aw_full && s_d.bus.w_full && !s_q.bus.bvalid) begin
            do_wr = 1'b1;
            wa = s_d.bus.aw_addr;
            s_d.bus.aw_full = 1'b0;
            s_d.bus.w_full = 1'b0;
            s_d.bus.bvalid = 1'b1;
        end

        if (do_wr) begin
            unique case (wa)
                `REG_CTRL: begin
                    wv = merge({29'h0, s_q.cc_mode, s_q.ack_manual},
                               s_d.bus.wdata, s_d.bus.wstrb);
                    s_d.ack_manual = wv[0];
                    s_d.cc_mode = uart_event_pkg::cc_mode_t'(wv[2:1]);
                end
                `REG_FIFO_THR: begin
                    wv = merge({25'h0, s_q.tx_thr, 1'b0, s_q.rx_thr},
                               s_d.bus.wdata, s_d.bus.wstrb);
                    s_d.rx_thr = wv[2:0];
                    s_d.tx_thr = wv[`THR_TX_LSB +: 3];
                end
                `REG_TX_DATA: begin
                    // a push into a full FIFO is dropped
                    tx_push = s_d.bus.wstrb[0] &&
                              (s_q.tx.cnt != 3'(`FIFO_DEPTH));
                end
                `REG_TMR0_CFG, `REG_TMR1_CFG: begin
                    for (int t = 0; t < 2; t++) begin
                        if (wa == ((t == 0) ? `REG_TMR0_CFG : `REG_TMR1_CFG))
                        begin
                            wv = merge({15'h0, s_q.tmr_baud[t], s_q.tmr_rel[t]},
                                       s_d.bus.wdata, s_d.bus.wstrb);
                            s_d.tmr_rel[t] = wv[TW-1:0];
                            s_d.tmr_baud[t] = wv[`TMR_MODE_BIT];
                        end
                    end
                end
                `REG_TMR_CMD: begin
                    if (s_d.bus.wstrb[0]) begin
                        load = s_d.bus.wdata[1:0];
                    end
                end
                `REG_USER_CC: begin
                    wv = merge({16'h0, s_q.user_cc}, s_d.bus.wdata,
                               s_d.bus.wstrb);
                    s_d.user_cc = wv[15:0];
                end
                `REG_INT_CLEAR: begin
                    wv = merge(32'h0, s_d.bus.wdata, s_d.bus.wstrb);
                    clr = wv[NSRC-1:0];
                end
                `REG_INT_ENABLE: begin
                    wv = merge({12'h0, s_q.src_en}, s_d.bus.wdata,
                               s_d.bus.wstrb);
                    s_d.src_en = wv[NSRC-1:0];
                end
                `REG_BLK_ENABLE: begin
                    wv = merge({26'h0, s_q.blk_en}, s_d.bus.wdata,
                               s_d.bus.wstrb);
                    s_d.blk_en = wv[NBLK-1:0];
                end
                `REG_RX_DATA, `REG_FIFO_STAT, `REG_TMR_STAT, `REG_INT_STATUS,
                `REG_TOP_BLOCK, `REG_BLK_SUMMARY: begin
                    wv = '0;
                end
                default: map_ok = 1'b0;
            endcase
            s_d.bus.bresp = map_ok ? `RESP_OKAY : `RESP_SLVERR;
        end

        // read channel; side effects happen when the address is taken
        if (RVALID_O && RREADY_I) begin
            s_d.bus.rvalid = 1'b0;
        end
        rd_fire = ARVALID_I && ARREADY_O;
        if (rd_fire) begin
            ra = ARADDR_I;
            map_ok = 1'b1;
            unique case (ra)
                `REG_CTRL: rv = {29'h0, s_q.cc_mode, s_q.ack_manual};
                `REG_FIFO_THR: rv = {25'h0, s_q.tx_thr, 1'b0, s_q.rx_thr};
                `REG_RX_DATA: begin
                    rx_pop = (s_q.rx.cnt != 3'h0);
                    rv = {23'h0, rx_pop, rx_head};
                    if (!s_q.ack_manual) begin
                        clr[`SRC_RXF_LO] = 1'b1;
                    end
                end
                `REG_FIFO_STAT: rv = {25'h0, s_q.tx.cnt, 1'b0, s_q.rx.cnt};
                `REG_TMR0_CFG: rv = {15'h0, s_q.tmr_baud[0], s_q.tmr_rel[0]};
                `REG_TMR1_CFG: rv = {15'h0, s_q.tmr_baud[1], s_q.tmr_rel[1]};
                `REG_TMR_STAT: begin
                    rv = {30'h0, s_q.pend[`SRC_TMR_HI:`SRC_TMR_LO]};
                    clr[`SRC_TMR_HI:`SRC_TMR_LO] = 2'b11;
                end
                `REG_USER_CC: rv = {16'h0, s_q.user_cc};
                `REG_INT_STATUS: rv = {12'h0, s_q.pend};
                `REG_INT_ENABLE: rv = {12'h0, s_q.src_en};
                `REG_BLK_ENABLE: rv = {26'h0, s_q.blk_en};
                `REG_TOP_BLOCK: begin
                    rv = {19'h0, top_src, 5'h0, top_blk};
                    if (!s_q.ack_manual) begin
                        clr = clr | blk_mask(top_blk);
                    end
                end
                `REG_BLK_SUMMARY: rv = {26'h0, blk_pend};
                `REG_TX_DATA, `REG_TMR_CMD, `REG_INT_CLEAR: rv = '0;
                default: map_ok = 1'b0;
            endcase
            s_d.bus.rvalid = 1'b1;
            s_d.bus.rdata = rv;
            s_d.bus.rresp = map_ok ? `RESP_OKAY : `RESP_SLVERR;
        end

        // receive FIFO
        if (rx_push) begin
            s_d.rx.wp = s_q.rx.wp + 2'h1;
        end
        if (rx_pop) begin
            s_d.rx.rp = s_q.rx.rp + 2'h1;
        end
        s_d.rx.cnt = s_q.rx.cnt + 3'(rx_push) - 3'(rx_pop);
        // zero threshold fires on the first character
        if (s_q.rx.cnt <= s_q.rx_thr && s_d.rx.cnt > s_q.rx_thr) begin
            set[`SRC_RXF_LO] = 1'b1;
        end
        set[`SRC_RXF_HI] = RX_CHAR_VALID_I && !rx_push;
        if (RX_CHAR_VALID_I) begin
            set[`SRC_RXM_LO] = cc_match(s_q.cc_mode, RX_CHAR_I,
                                        s_q.user_cc);
        end
        set[`SRC_RXM_HI:`SRC_RXM_LO + 5'd1] = RX_EVT_I;

        // transmit FIFO
        tx_pop = TX_CHAR_VALID_O && TX_CHAR_READY_I;
        if (tx_push) begin
            s_d.tx.wp = s_q.tx.wp + 2'h1;
        end
        if (tx_pop) begin
            s_d.tx.rp = s_q.tx.rp + 2'h1;
        end
        s_d.tx.cnt = s_q.tx.cnt + 3'(tx_push) - 3'(tx_pop);
        if (s_q.tx.cnt >= s_q.tx_thr && s_d.tx.cnt < s_q.tx_thr) begin
            set[`SRC_TXF_LO] = 1'b1;
        end
        set[`SRC_TXM_HI:`SRC_TXM_LO] = TX_EVT_I;

        // timers; baud mode reloads and ticks, timer mode stops at expiry
        for (int t = 0; t < 2; t++) begin
            s_d.tick[t] = 1'b0;
            if (load[t]) begin
                s_d.tmr_cnt[t] = s_q.tmr_rel[t];
                s_d.tmr_run[t] = 1'b1;
            end else if (s_q.tmr_run[t]) begin
                if (s_q.tmr_cnt[t] != '0) begin
                    s_d.tmr_cnt[t] = s_q.tmr_cnt[t] - TW'(1);
                end else if (s_q.tmr_baud[t]) begin
                    s_d.tmr_cnt[t] = s_q.tmr_rel[t];
                    s_d.tick[t] = 1'b1;
                end else begin
                    s_d.tmr_run[t] = 1'b0;
                    set[`SRC_TMR_LO + 5'(t)] = 1'b1;
                end
            end
        end

        // modem lines: the first stage feeds only the second
        s_d.mdm_s1 = MODEM_I;
        s_d.mdm_s2 = s_q.mdm_s1;
        s_d.mdm_s3 = s_q.mdm_s2;
        set[`SRC_MDM_HI:`SRC_MDM_LO] = s_q.mdm_s2 ^ s_q.mdm_s3;

        // sticky pending; a new event beats a clear in the same cycle
        s_d.pend = (s_q.pend & ~clr) | set;
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    char_fifo_mem #(.DEPTH(`FIFO_DEPTH), .WIDTH(8), .AW(2)) u_rx_mem (
        .clk_i(CLK_SYS_I),
        .we_i(rx_push),
        .waddr_i(s_q.rx.wp),
        .wdata_i(RX_CHAR_I),
        .raddr_i(s_d.rx.rp),
        .rdata_o(rx_head)
    );

    char_fifo_mem #(.DEPTH(`FIFO_DEPTH), .WIDTH(8), .AW(2)) u_tx_mem (
        .clk_i(CLK_SYS_I),
        .we_i(tx_push),
        .waddr_i(s_q.tx.wp),
        .wdata_i(s_d.bus.wdata[7:0]),
        .raddr_i(s_d.tx.rp),
        .rdata_o(tx_head)
    );

    // holding registers free up only once the write has been answered
    assign AWREADY_O = !s_q.bus.aw_full && !s_q.bus.bvalid;
    assign WREADY_O = !s_q.bus.w_full && !s_q.bus.bvalid;
    assign BVALID_O = s_q.bus.bvalid;
    assign BRESP_O = s_q.bus.bresp;
    assign ARREADY_O = !s_q.bus.rvalid;
    assign RVALID_O = s_q.bus.rvalid;
    assign RDATA_O = s_q.bus.rdata;
    assign RRESP_O = s_q.bus.rresp;
    assign TX_CHAR_O = tx_head;
    assign TX_CHAR_VALID_O = (s_q.tx.cnt != 3'h0);
    assign BAUD_TICK_O = s_q.tick;
    assign IRQ_O = |(blk_pend & s_q.blk_en);

endmodule : uart_event_offload

// ===== verification/uart_event_offload_sva.sv
// Purpose: port assertions of the serial event controller
// Assumes: one clock domain, reset active high
// Notes: bound to every instance of the top module
`timescale 1ns/100ps
module uart_event_offload_sva (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // register bus
    input wire logic AWVALID_I,
    input wire logic AWREADY_O,
    input wire logic WVALID_I,
    input wire logic WREADY_O,
    input wire logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [1:0] BRESP_O,
    input wire logic ARVALID_I,
    input wire logic ARREADY_O,
    input wire logic RVALID_O,
    input wire logic RREADY_I,
    input wire logic [31:0] RDATA_O,
    // stream, ticks and interrupt
    input wire logic [7:0] TX_CHAR_O,
    input wire logic TX_CHAR_VALID_O,
    input wire logic TX_CHAR_READY_I,
    input wire logic [1:0] BAUD_TICK_O,
    input wire logic IRQ_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    logic wr_t;
    logic rd_t;
    logic any_t;
    assign wr_t = AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
    assign rd_t = ARVALID_I && ARREADY_O;
    // any bus transfer may acknowledge, so only quiet cycles are judged
    assign any_t = rd_t || (AWVALID_I && AWREADY_O) || (WVALID_I && WREADY_O);
    a_write_resp: assert property (wr_t |=> BVALID_O)
        else $error("write not answered");
    a_bresp_hold: assert property (BVALID_O && !BREADY_I |=>
        BVALID_O && $stable(BRESP_O)) else $error("write response lost");
    a_b_blocks: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
        else $error("new write taken during response");
    a_read_resp: assert property (rd_t |=> RVALID_O)
        else $error("read not answered");
    a_rdata_hold: assert property (RVALID_O && !RREADY_I |=>
        RVALID_O && $stable(RDATA_O)) else $error("read data lost");
    a_r_done: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
        else $error("read response repeated");
    a_tx_hold: assert property (
        TX_CHAR_VALID_O && !TX_CHAR_READY_I |=>
        TX_CHAR_VALID_O && $stable(TX_CHAR_O)) else $error("tx head lost");
    a_irq_sticky: assert property (IRQ_O && !any_t |=> IRQ_O)
        else $error("interrupt dropped without service");
    c_irq: cover property ($rose(IRQ_O));
    c_slverr: cover property (BVALID_O && BRESP_O == 2'b10);
    c_tick: cover property (BAUD_TICK_O[1]);
endmodule : uart_event_offload_sva
bind uart_event_offload uart_event_offload_sva u_sva (.*);

// ===== verification/tx_char_sink.sv
// Purpose: far end of the transmit stream, pops at random
// Assumes: one pop per edge with valid and ready high
// Notes: stalls from the edge after go_i goes low; last four chars kept
`timescale 1ns/100ps
module tx_char_sink (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // transmit stream
    input wire logic [7:0] char_i,
    input wire logic valid_i,
    output logic ready_o,
    // bench side
    input wire logic go_i,
    output logic [31:0] got_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
            got_o <= '0;
        end else begin
            ready_o <= go_i && ($urandom_range(1, 0) == 1);
            if (ready_o && valid_i) begin
                got_o <= {got_o[23:0], char_i};
            end
        end
    end
endmodule : tx_char_sink

// ===== verification/tb.sv
// Purpose: self-checking bench of the serial event controller
// Assumes: registers as in uart_event_regs.svh
// Notes: timer counts stay short, no parameter override needed
`timescale 1ns/100ps
`include "uart_event_regs.svh"
module tb;
    logic CLK_SYS_I = 1'b0;
    logic RST_I = 1'b1;
    logic [7:0] AWADDR_I = '0, ARADDR_I = '0, RX_CHAR_I = '0, TX_CHAR_O;
    logic AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0, ARVALID_I = 0;
    logic RREADY_I = 0, RX_CHAR_VALID_I = 0, go = 0;
    logic [31:0] WDATA_I = '0, RDATA_O, got, d;
    logic [3:0] WSTRB_I = 4'hf;
    logic [4:0] RX_EVT_I = '0;
    logic [2:0] TX_EVT_I = '0;
    logic [5:0] MODEM_I = '0;
    logic [1:0] BRESP_O, RRESP_O, BAUD_TICK_O;
    logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
    logic TX_CHAR_VALID_O, TX_CHAR_READY_I, IRQ_O;
    logic [7:0] ch [4];
    int n_mismatch = 0, cmp_count = 0, t0, t1;
    uart_event_offload DUT (.*);
    tx_char_sink SINK (.clk_i(CLK_SYS_I), .rst_i(RST_I), .char_i(TX_CHAR_O),
        .valid_i(TX_CHAR_VALID_O), .ready_o(TX_CHAR_READY_I), .go_i(go),
        .got_o(got));
    always #4 CLK_SYS_I = ~CLK_SYS_I;
    function automatic logic [31:0] top(input int b, input int s);
        return (32'(s) << 8) | 32'(b);
    endfunction : top
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] v);
        AWADDR_I <= a;
        WDATA_I <= v;
        AWVALID_I <= 1'b1;
        WVALID_I <= 1'b1;
        BREADY_I <= 1'b1;
        do begin
            @(posedge CLK_SYS_I);
            if (AWREADY_O) AWVALID_I <= 1'b0;
            if (WREADY_O) WVALID_I <= 1'b0;
        end while (!BVALID_O);
        BREADY_I <= 1'b0;
        chk({30'h0, BRESP_O}, (a > `REG_BLK_SUMMARY) ? 32'h2 : 32'h0);
        // one idle edge so the next call never re-raises bready at once
        @(posedge CLK_SYS_I);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        ARADDR_I <= a;
        ARVALID_I <= 1'b1;
        RREADY_I <= 1'b1;
        do begin
            @(posedge CLK_SYS_I);
            if (ARREADY_O) ARVALID_I <= 1'b0;
            d = RDATA_O;
        end while (!RVALID_O);
        RREADY_I <= 1'b0;
        chk(d & m, e);
        chk({30'h0, RRESP_O}, (a > `REG_BLK_SUMMARY) ? 32'h2 : 32'h0);
        @(posedge CLK_SYS_I);
    endtask : rd
    task rx(input logic [7:0] v);
        RX_CHAR_I <= v;
        RX_CHAR_VALID_I <= 1'b1;
        @(posedge CLK_SYS_I);
        RX_CHAR_VALID_I <= 1'b0;
        @(posedge CLK_SYS_I);
    endtask : rx
    task irq(input logic e);
        repeat (3) @(posedge CLK_SYS_I);
        chk({31'h0, IRQ_O}, {31'h0, e});
    endtask : irq
    task conclude;
        $display("Checks %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end
    initial begin
        void'($urandom(32'hd8bb3e5c));
        repeat (8) @(posedge CLK_SYS_I);
        RST_I <= 1'b0;
        @(posedge CLK_SYS_I);
        rd(`REG_INT_STATUS, '1, 0);
        irq(0);
        rd(8'h40, '1, 0);
        wr(8'h40, '1);
        ch = '{8'h1b, 8'h3f, 8'h77, 8'($urandom_range(8'h1f, 8'h00))};
        wr(`REG_USER_CC, 32'h775a);
        for (int m = 0; m < 4; m++) begin
            // last pass: detection off, with a character ascii would flag
            wr(`REG_CTRL, 32'((m == 3) ? 6 : m * 2));
            wr(`REG_INT_CLEAR, '1);
            rx(ch[m]);
            rd(`REG_INT_STATUS, 1, (m < 3) ? 1 : 0);
        end
        rx(8'h41);
        rd(`REG_INT_STATUS, 32'h80, 32'h80);
        rd(`REG_FIFO_STAT, 32'h7, 32'h4);
        for (int i = 0; i < 4; i++) rd(`REG_RX_DATA, 32'h1ff, {1'b1, ch[i]});
        $display("control character test done");
        wr(`REG_FIFO_THR, 0);
        wr(`REG_INT_CLEAR, '1);
        wr(`REG_INT_ENABLE, 32'h40);
        wr(`REG_BLK_ENABLE, 32'h2);
        irq(0);
        rx(8'($urandom));
        irq(1);
        rd(`REG_TOP_BLOCK, 32'h1f07, top(1, 6));
        irq(0);
        wr(`REG_FIFO_THR, 2);
        rx(8'($urandom));
        irq(0);
        rx(8'($urandom));
        irq(1);
        $display("receive threshold test done");
        wr(`REG_CTRL, 1);
        wr(`REG_INT_CLEAR, '1);
        wr(`REG_INT_ENABLE, 32'hfc202);
        wr(`REG_BLK_ENABLE, 0);
        RX_EVT_I <= 5'h1;
        TX_EVT_I <= 3'h1;
        @(posedge CLK_SYS_I);
        RX_EVT_I <= 5'h0;
        TX_EVT_I <= 3'h0;
        irq(0);
        rd(`REG_BLK_SUMMARY, 32'h3f, 32'h9);
        wr(`REG_BLK_ENABLE, 32'h3f);
        rd(`REG_TOP_BLOCK, 32'h1f07, top(0, 1));
        irq(1);
        wr(`REG_INT_CLEAR, 32'h202);
        irq(0);
        MODEM_I <= 6'($urandom_range(63, 1));
        repeat (6) @(posedge CLK_SYS_I);
        rd(`REG_INT_STATUS, '1, 32'(MODEM_I) << 14);
        $display("mask and acknowledge test done");
        wr(`REG_CTRL, 0);
        t0 = $urandom_range(30, 5);
        wr(`REG_TMR0_CFG, 32'(t0));
        wr(`REG_INT_CLEAR, '1);
        wr(`REG_INT_ENABLE, 32'h1000);
        wr(`REG_TMR_CMD, 1);
        repeat (t0 - 1) @(posedge CLK_SYS_I);
        chk({31'h0, IRQ_O}, 0);
        @(posedge CLK_SYS_I);
        chk({31'h0, IRQ_O}, 1);
        rd(`REG_TMR_STAT, 3, 1);
        rd(`REG_TMR_STAT, 3, 0);
        irq(0);
        wr(`REG_TMR0_CFG, 32'h10003);
        wr(`REG_TMR1_CFG, 32'h10005);
        wr(`REG_TMR_CMD, 3);
        repeat (10) @(posedge CLK_SYS_I);
        t0 = 0;
        t1 = 0;
        for (int i = 0; i < 60; i++) begin
            @(posedge CLK_SYS_I);
            t0 += int'(BAUD_TICK_O[0]);
            t1 += int'(BAUD_TICK_O[1]);
        end
        chk(32'(t0), 15);
        chk(32'(t1), 10);
        $display("timer test done");
        wr(`REG_FIFO_THR, 32'h20);
        wr(`REG_INT_CLEAR, '1);
        wr(`REG_INT_ENABLE, 32'h100);
        wr(`REG_BLK_ENABLE, 32'h4);
        for (int i = 0; i < 4; i++) begin
            ch[i] = 8'($urandom);
            wr(`REG_TX_DATA, 32'(ch[i]));
        end
        wr(`REG_TX_DATA, 32'hee);
        rd(`REG_FIFO_STAT, 32'h70, 32'h40);
        irq(0);
        go <= 1'b1;
        repeat (100) @(posedge CLK_SYS_I);
        go <= 1'b0;
        chk(got, {ch[0], ch[1], ch[2], ch[3]});
        irq(1);
        $display("transmit threshold test done");
        conclude();
    end
endmodule : tb
